// ===== pkg/sds_pkg.sv
package sds_pkg;
    // frame identifiers, added to the node number
    localparam logic [10:0] REQ_ID_BASE = 11'h600;
    localparam logic [10:0] RESP_ID_BASE = 11'h580;

    // field positions inside the 64-bit frame, byte D1 at bit 0
    localparam int CTRL_LSB = 0;
    localparam int KEY_LSB = 8;
    localparam int DATA_LSB = 32;

    // control byte values
    localparam logic [7:0] CTRL_WRITE = 8'h23;
    localparam logic [7:0] CTRL_READ = 8'h40;
    localparam logic [7:0] CTRL_WRITE_OK = 8'h60;
    localparam logic [7:0] CTRL_READ_OK = 8'h43;
    localparam logic [7:0] CTRL_ABORT = 8'h80;
    localparam logic [2:0] CMD_DOWNLOAD = 3'h1;

    // abort codes
    localparam logic [31:0] ERR_READ_ONLY = 32'h06010002;
    localparam logic [31:0] ERR_NO_OBJ = 32'h06020000;
    localparam logic [31:0] ERR_SIZE = 32'h06070010;

    // object keys as {subindex, index high, index low}
    localparam logic [23:0] KEY_CONS_CNT = 24'h001016;
    localparam logic [23:0] KEY_CONS_HB = 24'h011016;
    localparam logic [23:0] KEY_PROD_HB = 24'h001017;
    localparam logic [23:0] KEY_HW_INFO = 24'h002000;
    localparam logic [23:0] KEY_SW_INFO = 24'h002001;
    localparam logic [23:0] KEY_BAUD = 24'h002002;
    localparam logic [23:0] KEY_PDO_CFG = 24'h002003;
    localparam logic [23:0] KEY_COUNTERS = 24'h002004;
    localparam logic [23:0] KEY_AIN_MODE = 24'h002005;
    localparam logic [23:0] KEY_PWM_SEL = 24'h002006;
    localparam logic [23:0] KEY_PWM_CYCLE = 24'h002007;
    localparam logic [23:0] KEY_FUSE_TEST = 24'h002008;

    // storage slots of writable objects
    localparam int SLOT_W = 3;
    localparam int N_SLOTS = 8;
    localparam logic [2:0] SLOT_CONS_HB = 3'h0;
    localparam logic [2:0] SLOT_PROD_HB = 3'h1;
    localparam logic [2:0] SLOT_PDO_CFG = 3'h2;
    localparam logic [2:0] SLOT_COUNTERS = 3'h3;
    localparam logic [2:0] SLOT_AIN_MODE = 3'h4;
    localparam logic [2:0] SLOT_PWM_SEL = 3'h5;
    localparam logic [2:0] SLOT_PWM_CYCLE = 3'h6;
    localparam logic [2:0] SLOT_FUSE_TEST = 3'h7;

    // significant payload bits per object
    localparam logic [31:0] MASK_24 = 32'h00FFFFFF;
    localparam logic [31:0] MASK_16 = 32'h0000FFFF;
    localparam logic [31:0] MASK_8 = 32'h000000FF;
    localparam logic [31:0] MASK_4 = 32'h0000000F;

    // heartbeat entry counts
    localparam logic [31:0] HB_ENTRIES = 32'h00000001;
    localparam logic [31:0] STORE_RESET = 32'h00000000;
endpackage

// ===== src/sds_obj_store.sv
`timescale 1ns/1ps
module sds_obj_store #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8,
    parameter int AW = 3
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // write port
    input wire logic wrEn,
    input wire logic [AW-1:0] wrAddr,
    input wire logic [WIDTH-1:0] wrData,
    // read port, data one cycle after the enable
    input wire logic rdEn,
    input wire logic [AW-1:0] rdAddr,
    output logic [WIDTH-1:0] rdData
);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] rdData_q;

    // object words, cleared at reset so reads never return unknowns
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
        end else if (wrEn) begin
            mem_q[wrAddr] <= wrData;
        end
    end

    // registered read data
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rdData_q <= '0;
        end else if (rdEn) begin
            rdData_q <= mem_q[rdAddr];
        end
    end

    assign rdData = rdData_q;
endmodule

// ===== src/sds_server.sv
`timescale 1ns/1ps
module sds_server
    import sds_pkg::*;
#(
    parameter logic [7:0] HW_TYPE = 8'h01,
    parameter logic [23:0] HW_VERSION = 24'h010000, // arbitrary value
    parameter logic [23:0] SW_VERSION = 24'h010000, // arbitrary value
    parameter logic [7:0] BAUD_CODE = 8'h00
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // own node number
    input wire logic [6:0] nodeId,
    // request frame from the can controller
    input wire logic rxValid,
    input wire logic [10:0] rxId,
    input wire logic [63:0] rxData,
    output logic rxReady,
    // response frame to the can controller
    output logic txValid,
    output logic [10:0] txId,
    output logic [63:0] txData,
    input wire logic txReady,
    // mirror of accepted object writes
    output logic objWrStb,
    output logic [2:0] objWrSlot,
    output logic [31:0] objWrValue
);
    typedef enum logic [1:0] {ST_IDLE, ST_DECODE, ST_FETCH, ST_SEND} sds_state_t;

    sds_state_t state_q;
    logic rxReady_q;
    logic [63:0] reqData_q;
    logic txValid_q;
    logic [10:0] txId_q;
    logic [63:0] txData_q;
    logic objWrStb_q;
    logic [2:0] objWrSlot_q;
    logic [31:0] objWrValue_q;
    logic ownFrame;
    logic acceptAny;
    logic acceptOwn;
    logic [7:0] reqCtrl;
    logic [23:0] reqKey;
    logic [31:0] reqPayload;
    logic [5:0] info;
    logic hit;
    logic wrOk;
    logic rdConst;
    logic [2:0] slot;
    logic [7:0] respCtrl;
    logic [31:0] respVal;
    logic needFetch;
    logic doWrite;
    logic memWrEn;
    logic memRdEn;
    logic [31:0] memRdData;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    // object table entry: {hit, writable, constant read, slot}
    function automatic logic [5:0] objInfo(input logic [23:0] key);
        unique case (key)
            KEY_CONS_CNT: objInfo = {3'b101, SLOT_CONS_HB};
            KEY_CONS_HB: objInfo = {3'b110, SLOT_CONS_HB};
            KEY_PROD_HB: objInfo = {3'b111, SLOT_PROD_HB};
            KEY_HW_INFO: objInfo = {3'b101, SLOT_CONS_HB};
            KEY_SW_INFO: objInfo = {3'b101, SLOT_CONS_HB};
            KEY_BAUD: objInfo = {3'b101, SLOT_CONS_HB};
            KEY_PDO_CFG: objInfo = {3'b110, SLOT_PDO_CFG};
            KEY_COUNTERS: objInfo = {3'b110, SLOT_COUNTERS};
            KEY_AIN_MODE: objInfo = {3'b110, SLOT_AIN_MODE};
            KEY_PWM_SEL: objInfo = {3'b110, SLOT_PWM_SEL};
            KEY_PWM_CYCLE: objInfo = {3'b110, SLOT_PWM_CYCLE};
            KEY_FUSE_TEST: objInfo = {3'b110, SLOT_FUSE_TEST};
            default: objInfo = 6'h00;
        endcase
    endfunction

    // significant bits of each stored object
    function automatic logic [31:0] slotMask(input logic [2:0] s);
        unique case (s)
            SLOT_CONS_HB: slotMask = MASK_24;
            SLOT_PROD_HB: slotMask = MASK_16;
            SLOT_PDO_CFG: slotMask = MASK_24;
            SLOT_COUNTERS: slotMask = MASK_16;
            SLOT_AIN_MODE: slotMask = MASK_4;
            SLOT_PWM_SEL: slotMask = MASK_24;
            SLOT_PWM_CYCLE: slotMask = MASK_24;
            SLOT_FUSE_TEST: slotMask = MASK_8;
        endcase
    endfunction

    // values of objects whose read answer is fixed
    function automatic logic [31:0] constValue(input logic [23:0] key);
        unique case (key)
            KEY_CONS_CNT: constValue = HB_ENTRIES;
            KEY_PROD_HB: constValue = HB_ENTRIES;
            KEY_HW_INFO: constValue = {HW_VERSION, HW_TYPE};
            KEY_SW_INFO: constValue = {SW_VERSION, 8'h00};
            KEY_BAUD: constValue = {24'h000000, BAUD_CODE};
            default: constValue = STORE_RESET;
        endcase
    endfunction

    // address filter and handshake
    assign ownFrame = (rxId == REQ_ID_BASE + {4'h0, nodeId});
    assign acceptAny = rxValid && rxReady_q;
    assign acceptOwn = acceptAny && ownFrame;

    // fields of the held request, index low byte first
    assign reqCtrl = reqData_q[CTRL_LSB +: 8];
    assign reqKey = reqData_q[KEY_LSB +: 24];
    assign reqPayload = reqData_q[DATA_LSB +: 32];
    assign info = objInfo(reqKey);
    assign hit = info[5];
    assign wrOk = info[4];
    assign rdConst = info[3];
    assign slot = info[2:0];

    // outcome of the held request, checks in priority order
    always_comb begin
        respCtrl = CTRL_ABORT;
        respVal = ERR_NO_OBJ;
        needFetch = 1'b0;
        doWrite = 1'b0;
        if (reqCtrl[7:5] == CMD_DOWNLOAD) begin
            if (!hit) begin
                respVal = ERR_NO_OBJ;
            end else if (!wrOk) begin
                respVal = ERR_READ_ONLY;
            end else if (reqCtrl != CTRL_WRITE) begin
                respVal = ERR_SIZE;
            end else begin
                respCtrl = CTRL_WRITE_OK;
                respVal = STORE_RESET;
                doWrite = 1'b1;
            end
        end else if (reqCtrl == CTRL_READ && hit) begin
            respCtrl = CTRL_READ_OK;
            respVal = constValue(reqKey);
            needFetch = !rdConst;
        end
    end

    // sequencer: one request in flight at a time
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= ST_IDLE;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (acceptOwn) begin
                        state_q <= ST_DECODE;
                    end
                end
                ST_DECODE: state_q <= needFetch ? ST_FETCH : ST_SEND;
                ST_FETCH: state_q <= ST_SEND;
                ST_SEND: begin
                    if (txReady) begin
                        state_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // request side ready, dropped while a request is being served
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rxReady_q <= 1'b1;
        end else if (acceptOwn) begin
            rxReady_q <= 1'b0;
        end else if (state_q == ST_SEND && txReady) begin
            rxReady_q <= 1'b1;
        end
    end

    // request hold register
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            reqData_q <= '0;
        end else if (acceptOwn) begin
            reqData_q <= rxData;
        end
    end

    // object storage
    assign memWrEn = (state_q == ST_DECODE) && doWrite;
    assign memRdEn = (state_q == ST_DECODE) && needFetch;

    sds_obj_store #(
        .WIDTH(32),
        .DEPTH(N_SLOTS),
        .AW(SLOT_W)
    ) u_store (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .wrEn(memWrEn),
        .wrAddr(slot),
        .wrData(reqPayload & slotMask(slot)),
        .rdEn(memRdEn),
        .rdAddr(slot),
        .rdData(memRdData)
    );

    // response frame, key echoed, value least significant byte first
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            txValid_q <= 1'b0;
            txId_q <= '0;
            txData_q <= '0;
        end else if (state_q == ST_DECODE && !needFetch) begin
            txValid_q <= 1'b1;
            txId_q <= RESP_ID_BASE + {4'h0, nodeId};
            txData_q <= {respVal, reqKey, respCtrl};
        end else if (state_q == ST_FETCH) begin
            txValid_q <= 1'b1;
            txId_q <= RESP_ID_BASE + {4'h0, nodeId};
            txData_q <= {memRdData, reqKey, CTRL_READ_OK};
        end else if (state_q == ST_SEND && txReady) begin
            txValid_q <= 1'b0;
        end
    end

    // write mirror toward the i/o functions
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            objWrStb_q <= 1'b0;
            objWrSlot_q <= '0;
            objWrValue_q <= '0;
        end else begin
            objWrStb_q <= memWrEn;
            if (memWrEn) begin
                objWrSlot_q <= slot;
                objWrValue_q <= reqPayload & slotMask(slot);
            end
        end
    end

    // outputs straight from flops
    assign rxReady = rxReady_q;
    assign txValid = txValid_q;
    assign txId = txId_q;
    assign txData = txData_q;
    assign objWrStb = objWrStb_q;
    assign objWrSlot = objWrSlot_q;
    assign objWrValue = objWrValue_q;

    // checks
    property p_answer_time;
        acceptOwn |-> ##[2:3] txValid_q;
    endproperty
    a_answer_time: assert property (p_answer_time) else $error("no answer in time");

    property p_no_unsolicited;
        $rose(txValid_q) |-> $past(state_q) == ST_DECODE || $past(state_q) == ST_FETCH;
    endproperty
    a_no_unsolicited: assert property (p_no_unsolicited) else $error("unsolicited frame");

    property p_foreign_drop;
        acceptAny && !ownFrame && !txValid_q |=> rxReady_q && !txValid_q;
    endproperty
    a_foreign_drop: assert property (p_foreign_drop) else $error("foreign frame served");

    property p_resp_id;
        txValid_q |-> txId_q == RESP_ID_BASE + {4'h0, nodeId};
    endproperty
    a_resp_id: assert property (p_resp_id) else $error("wrong response id");

    property p_write_ok;
        acceptOwn && rxData[7:0] == CTRL_WRITE && rxData[31:8] == KEY_COUNTERS
            |-> ##2 txData_q == {STORE_RESET, KEY_COUNTERS, CTRL_WRITE_OK};
    endproperty
    a_write_ok: assert property (p_write_ok) else $error("bad positive response");

    property p_echo;
        $rose(txValid_q) |-> txData_q[31:8] == reqKey;
    endproperty
    a_echo: assert property (p_echo) else $error("key not echoed");

    property p_read_only;
        acceptOwn && rxData[7:0] == CTRL_WRITE && rxData[31:8] == KEY_CONS_CNT
            |-> ##2 txData_q == {ERR_READ_ONLY, KEY_CONS_CNT, CTRL_ABORT};
    endproperty
    a_read_only: assert property (p_read_only) else $error("read-only write not refused");

    property p_unknown;
        acceptOwn && rxData[31:8] == 24'h003000
            |-> ##2 txData_q[7:0] == CTRL_ABORT && txData_q[63:32] == ERR_NO_OBJ;
    endproperty
    a_unknown: assert property (p_unknown) else $error("unknown object not refused");

    property p_size;
        acceptOwn && rxData[7:0] == 8'h27 && rxData[31:8] == KEY_PDO_CFG
            |-> ##2 txData_q[63:32] == ERR_SIZE && !objWrStb_q;
    endproperty
    a_size: assert property (p_size) else $error("size mismatch not refused");

    property p_cons_count;
        acceptOwn && rxData[7:0] == CTRL_READ && rxData[31:8] == KEY_CONS_CNT
            |-> ##2 txData_q == {HB_ENTRIES, KEY_CONS_CNT, CTRL_READ_OK};
    endproperty
    a_cons_count: assert property (p_cons_count) else $error("bad consumer count");

    property p_prod_count;
        acceptOwn && rxData[7:0] == CTRL_READ && rxData[31:8] == KEY_PROD_HB
            |-> ##2 txData_q == {HB_ENTRIES, KEY_PROD_HB, CTRL_READ_OK};
    endproperty
    a_prod_count: assert property (p_prod_count) else $error("bad producer count");

    property p_cons_hb_read;
        acceptOwn && rxData[7:0] == CTRL_READ && rxData[31:8] == KEY_CONS_HB
            |-> ##3 txValid_q && txData_q[7:0] == CTRL_READ_OK && txData_q[63:56] == 8'h00;
    endproperty
    a_cons_hb_read: assert property (p_cons_hb_read) else $error("bad heartbeat read");

    property p_store_mask;
        objWrStb_q && objWrSlot_q == SLOT_PROD_HB |-> objWrValue_q[31:16] == 16'h0000;
    endproperty
    a_store_mask: assert property (p_store_mask) else $error("unused bytes kept");
endmodule

// ===== test/sds_master_model.sv
`timescale 1ns/1ps
module sds_master_model (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // request frame towards the server
    output logic rxValid,
    output logic [10:0] rxId,
    output logic [63:0] rxData,
    input wire logic rxReady,
    // response frame from the server
    input wire logic txValid,
    input wire logic [10:0] txId,
    input wire logic [63:0] txData,
    output logic txReady
);
    // cycles the master lets a pending response wait before taking it
    int stall = 0;

    // idle levels at time zero
    initial begin
        rxValid = 1'b0;
        rxId = 11'h000;
        rxData = 64'h0;
        txReady = 1'b0;
    end

    // only the master opens an exchange: one frame out, then its answer, if any
    task automatic xfer(input logic [10:0] id, input logic [7:0] ctrl, input logic [23:0] key,
        input logic [31:0] data, input int waitMax, output logic got,
        output logic [10:0] rId, output logic [63:0] rData, output int holdErr);
        int n;
        got = 1'b0;
        rId = 11'h000;
        rData = 64'h0;
        holdErr = 0;
        @(posedge clk_sys);
        rxValid <= 1'b1;
        rxId <= id;
        rxData <= {data, key, ctrl};
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (rxReady !== 1'b1 && n < 50);
        // released lines show the inverse so a stale value is never mistaken for live
        rxValid <= 1'b0;
        rxId <= ~id;
        rxData <= ~{data, key, ctrl};
        n = 0;
        while (txValid !== 1'b1 && n < waitMax) begin
            @(posedge clk_sys);
            n++;
        end
        if (txValid === 1'b1) begin
            got = 1'b1;
            // slow master: the frame must stand and no new request may be taken
            for (int i = 0; i < stall; i++) begin
                if (rxReady !== 1'b0 || txValid !== 1'b1) holdErr++;
                @(posedge clk_sys);
            end
            txReady <= 1'b1;
            @(posedge clk_sys);
            rId = txId;
            rData = txData;
            txReady <= 1'b0;
        end
    endtask
endmodule

// ===== test/sds_server_tb.sv
`timescale 1ns/1ps
module sds_server_tb
    import sds_pkg::*;
;
    typedef struct {
        logic [7:0] ctrl;
        logic [23:0] key;
        logic [31:0] data;
        logic [7:0] eCtrl;
        logic [31:0] eData;
    } sds_row_t;

    localparam logic [6:0] NODE = 7'h05;
    localparam logic [10:0] REQ = 11'h605;
    localparam logic [10:0] RESP = 11'h585;

    logic clk_sys;
    logic reset_n;
    logic [6:0] nodeId;
    logic rxValid;
    logic [10:0] rxId;
    logic [63:0] rxData;
    logic rxReady;
    logic txValid;
    logic [10:0] txId;
    logic [63:0] txData;
    logic txReady;
    logic objWrStb;
    logic [2:0] objWrSlot;
    logic [31:0] objWrValue;
    int miscompares = 0;
    int check_count = 0;
    int stbCount = 0;
    sds_row_t rows [14];

    // design under test
    sds_server dut_u (
        .clk_sys(clk_sys), .reset_n(reset_n), .nodeId(nodeId),
        .rxValid(rxValid), .rxId(rxId), .rxData(rxData), .rxReady(rxReady),
        .txValid(txValid), .txId(txId), .txData(txData), .txReady(txReady),
        .objWrStb(objWrStb), .objWrSlot(objWrSlot), .objWrValue(objWrValue)
    );

    // can master on the far side
    sds_master_model master_u (
        .clk_sys(clk_sys), .reset_n(reset_n),
        .rxValid(rxValid), .rxId(rxId), .rxData(rxData), .rxReady(rxReady),
        .txValid(txValid), .txId(txId), .txData(txData), .txReady(txReady)
    );

    // 10 MHz clock
    initial clk_sys = 1'b0;
    always #50 clk_sys = ~clk_sys;

    // count write mirror pulses
    always @(posedge clk_sys) begin
        if (objWrStb === 1'b1) stbCount++;
    end

    // compare and report
    task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // verdict
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // one request, answer compared in full
    task automatic run(input logic [7:0] ctrl, input logic [23:0] key, input logic [31:0] data,
        input logic [7:0] eCtrl, input logic [31:0] eData);
        logic got;
        logic [10:0] rId;
        logic [63:0] rData;
        int holdErr;
        master_u.xfer(REQ, ctrl, key, data, 20, got, rId, rData, holdErr);
        chk("answered", {63'h0, got}, 64'h1);
        chk("txId", {53'h0, rId}, {53'h0, RESP});
        chk("txData", rData, {eData, key, eCtrl});
        chk("holdErr", 64'(holdErr), 64'h0);
    endtask

    // main sequence
    initial begin
        logic got;
        logic [10:0] rId;
        logic [63:0] rData;
        int holdErr;
        reset_n = 1'b0;
        nodeId = NODE;
        rows = '{
            '{8'h23, 24'h011016, 32'h000503E8, 8'h60, 32'h00000000},
            '{8'h40, 24'h011016, 32'h00000000, 8'h43, 32'h000503E8},
            '{8'h23, 24'h001016, 32'h00000002, 8'h80, 32'h06010002},
            '{8'h40, 24'h001016, 32'h00000000, 8'h43, 32'h00000001},
            '{8'h23, 24'h001017, 32'hAABB00C8, 8'h60, 32'h00000000},
            '{8'h40, 24'h001017, 32'h00000000, 8'h43, 32'h00000001},
            '{8'h23, 24'h002004, 32'hAABB0201, 8'h60, 32'h00000000},
            '{8'h40, 24'h002004, 32'h00000000, 8'h43, 32'h00000201},
            '{8'h23, 24'h002000, 32'h00000001, 8'h80, 32'h06010002},
            '{8'h23, 24'h003000, 32'h00000001, 8'h80, 32'h06020000},
            '{8'h27, 24'h002003, 32'h00000001, 8'h80, 32'h06070010},
            '{8'h40, 24'h005000, 32'h00000000, 8'h80, 32'h06020000},
            '{8'h23, 24'h002005, 32'hFFFFFFFF, 8'h60, 32'h00000000},
            '{8'h40, 24'h002005, 32'h00000000, 8'h43, 32'h0000000F}
        };
        repeat (3) @(posedge clk_sys);
        reset_n <= 1'b1;
        // table of ordinary requests
        for (int r = 0; r < 14; r++) begin
            run(rows[r].ctrl, rows[r].key, rows[r].data, rows[r].eCtrl, rows[r].eData);
            $display("row %0d done", r);
        end
        chk("stbCount", 64'(stbCount), 64'h4);
        chk("objWrSlot", {61'h0, objWrSlot}, 64'h4);
        chk("objWrValue", {32'h0, objWrValue}, 64'h0000000F);
        $display("mirror test done");
        // slow master: response waits, next request held off
        master_u.stall = 4;
        run(8'h23, 24'h002008, 32'h123456AB, 8'h60, 32'h00000000);
        master_u.stall = 0;
        run(8'h40, 24'h002008, 32'h00000000, 8'h43, 32'h000000AB);
        $display("stall test done");
        // frame for another node is taken but never answered
        master_u.xfer(11'h606, 8'h40, 24'h001016, 32'h0, 12, got, rId, rData, holdErr);
        chk("foreign answered", {63'h0, got}, 64'h0);
        run(8'h40, 24'h001017, 32'h00000000, 8'h43, 32'h00000001);
        $display("foreign id test done");
        // reset in mid-run clears the store
        @(posedge clk_sys);
        reset_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        chk("rxReady in reset", {63'h0, rxReady}, 64'h1);
        chk("txValid in reset", {63'h0, txValid}, 64'h0);
        chk("txData in reset", txData, 64'h0);
        reset_n <= 1'b1;
        run(8'h40, 24'h011016, 32'h00000000, 8'h43, 32'h00000000);
        $display("reset test done");
        // another node number moves both the filter and the response id
        nodeId <= 7'h7F;
        master_u.xfer(11'h67F, 8'h40, 24'h001017, 32'h0, 20, got, rId, rData, holdErr);
        chk("node answered", {63'h0, got}, 64'h1);
        chk("node txId", {53'h0, rId}, 64'h00000000000005FF);
        chk("node txData", rData, {HB_ENTRIES, KEY_PROD_HB, CTRL_READ_OK});
        $display("node number test done");
        end_sim();
    end

    // watchdog well beyond the expected run
    initial begin
        #2000000;
        miscompares++;
        $display("MISMATCH watchdog expected done seen timeout");
        end_sim();
    end
endmodule
